// file: config_store.sv
// Per-channel tunable configuration words, two channels side by side.
// Assumes a write mask may hit both channels in one cycle.
`timescale 1ns/1ps
`default_nettype none
module config_store
  import serdes_prov_pkg::*;
#(
  parameter int unsigned W     = DATA_W,
  parameter int unsigned IDX_W = CFG_IDX_W
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             clockEnable,
  input  wire logic             softClear,
  input  wire logic             writeEnable,
  input  wire logic [1:0]       writeMask,
  input  wire logic [IDX_W-1:0] writeIndex,
  input  wire logic [W-1:0]     writeData,
  input  wire logic             readChan,
  input  wire logic [IDX_W-1:0] readIndex,
  output var  logic [W-1:0]     readData
);

  if (W != DATA_W || IDX_W != CFG_IDX_W) begin : g_bad_shape
    $error("config_store shape not supported");
  end

  logic [W-1:0] mem_q [2][2**IDX_W];
  logic [W-1:0] mem_d [2][2**IDX_W];
  logic [W-1:0] readData_d;

  always_comb begin
    mem_d = mem_q;
    readData_d = mem_q[readChan][readIndex];
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 2**IDX_W; i++) begin
        if (softClear) begin
          mem_d[c][i] = cfg_reset_value(IDX_W'(i));
        end
      end
      if (!softClear && writeEnable && writeMask[c]) begin
        mem_d[c][writeIndex] = writeData;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int c = 0; c < 2; c++) begin
        for (int i = 0; i < 2**IDX_W; i++) begin
          mem_q[c][i] <= cfg_reset_value(IDX_W'(i));
        end
      end
      readData <= '0;
    end else if (clockEnable) begin
      mem_q <= mem_d;
      readData <= readData_d;
    end
  end

endmodule // config_store
`default_nettype wire

// file: mdio_frame_engine.sv
// Management frame engine on the link clock: decodes frames, drives read data.
// Assumes register access completes within one link clock via toggle handshake.
`timescale 1ns/1ps
`default_nettype none
module mdio_frame_engine
  import serdes_prov_pkg::*;
#(
  parameter logic [4:0] PHY_BASE = 5'h00
) (
  input  wire logic        mdc,
  input  wire logic        reset,
  input  wire logic        mdioIn,
  output var  logic        mdioOut,
  output var  logic        mdioOe,
  input  wire logic [15:0] rdWord,
  input  wire logic        ackToggle,
  output var  logic        reqChan,
  output var  logic [4:0]  reqReg,
  output var  logic [15:0] reqData,
  output var  logic        rdToggle,
  output var  logic        wrToggle
);

  if (PHY_BASE[0] != 1'b0) begin : g_bad_base
    $error("PHY_BASE must be even");
  end

  frame_state_t state_q, state_d;
  logic [5:0]  ones_q, ones_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [10:0] hdr_q, hdr_d;
  logic [15:0] data_q, data_d;
  logic        isRead_q, isRead_d;
  logic        chan_q, chan_d;
  logic [4:0]  reg_q, reg_d;
  logic        rdTog_q, rdTog_d;
  logic        wrTog_q, wrTog_d;
  logic        ackMeta_q, ackSync_q;
  logic        oeNeg_q, oeNeg_d;
  logic        outNeg_q, outNeg_d;
  logic [11:0] full;

  always_comb begin
    state_d = state_q;
    ones_d = 6'd0;
    cnt_d = cnt_q;
    hdr_d = hdr_q;
    data_d = data_q;
    isRead_d = isRead_q;
    chan_d = chan_q;
    reg_d = reg_q;
    rdTog_d = rdTog_q;
    wrTog_d = wrTog_q;
    full = {hdr_q, mdioIn};
    case (state_q)
      FR_PREAMBLE: begin
        if (mdioIn) begin
          ones_d = (ones_q == PREAMBLE_LEN) ? ones_q : ones_q + 6'd1;
        end else if (ones_q == PREAMBLE_LEN) begin
          state_d = FR_START;
        end
      end
      FR_START: begin
        cnt_d = 4'd0;
        state_d = mdioIn ? FR_HEADER : FR_PREAMBLE;
      end
      FR_HEADER: begin
        hdr_d = full[10:0];
        cnt_d = cnt_q + 4'd1;
        if (cnt_q == HDR_LAST) begin
          cnt_d = 4'd0;
          state_d = FR_PREAMBLE;
          if (full[9:6] == PHY_BASE[4:1] &&
              (full[11:10] == OP_READ || full[11:10] == OP_WRITE)) begin
            state_d = FR_TURN;
            isRead_d = (full[11:10] == OP_READ);
            chan_d = full[5];
            reg_d = full[4:0];
            if (full[11:10] == OP_READ) begin
              rdTog_d = ~rdTog_q;
            end
          end
        end
      end
      FR_TURN: begin
        cnt_d = cnt_q + 4'd1;
        if (cnt_q == TA_LAST) begin
          cnt_d = 4'd0;
          state_d = FR_DATA;
        end
      end
      FR_DATA: begin
        cnt_d = cnt_q + 4'd1;
        if (!isRead_q) begin
          data_d = {data_q[14:0], mdioIn};
        end
        if (cnt_q == DATA_LAST) begin
          cnt_d = 4'd0;
          state_d = FR_PREAMBLE;
          if (!isRead_q) begin
            wrTog_d = ~wrTog_q;
          end
        end
      end
      default: state_d = FR_PREAMBLE;
    endcase
  end

  // Read data changes on the falling edge, sampled by the host on the rising
  always_comb begin
    oeNeg_d = 1'b0;
    outNeg_d = 1'b1;
    if (isRead_q && state_q == FR_TURN && cnt_q == TA_LAST) begin
      oeNeg_d = 1'b1;
      outNeg_d = 1'b0;
    end
    if (isRead_q && state_q == FR_DATA) begin
      oeNeg_d = 1'b1;
      outNeg_d = (ackSync_q == rdTog_q) ? rdWord[DATA_LAST - cnt_q] : 1'b1;
    end
  end

  always_ff @(posedge mdc or posedge reset) begin
    if (reset) begin
      state_q <= FR_PREAMBLE;
      ones_q <= 6'd0;
      cnt_q <= 4'd0;
      hdr_q <= '0;
      data_q <= '0;
      isRead_q <= 1'b0;
      chan_q <= 1'b0;
      reg_q <= '0;
      rdTog_q <= 1'b0;
      wrTog_q <= 1'b0;
      ackMeta_q <= 1'b0;
      ackSync_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ones_q <= ones_d;
      cnt_q <= cnt_d;
      hdr_q <= hdr_d;
      data_q <= data_d;
      isRead_q <= isRead_d;
      chan_q <= chan_d;
      reg_q <= reg_d;
      rdTog_q <= rdTog_d;
      wrTog_q <= wrTog_d;
      ackMeta_q <= ackToggle;
      ackSync_q <= ackMeta_q;
    end
  end

  always_ff @(negedge mdc or posedge reset) begin
    if (reset) begin
      oeNeg_q <= 1'b0;
      outNeg_q <= 1'b1;
    end else begin
      oeNeg_q <= oeNeg_d;
      outNeg_q <= outNeg_d;
    end
  end

  // Drive released on the frame's last rising edge
  assign mdioOe = oeNeg_q & isRead_q & (state_q == FR_TURN || state_q == FR_DATA);
  assign mdioOut = outNeg_q;
  assign reqChan = chan_q;
  assign reqReg = reg_q;
  assign reqData = data_q;
  assign rdToggle = rdTog_q;
  assign wrToggle = wrTog_q;

endmodule // mdio_frame_engine
`default_nettype wire

// file: mdio_host_model.sv
// Management host model: makes mdc only within frames and idle calls, drives the line.
// Assumes a pull-up on the shared line; device drives it when mdioOe is high.
`timescale 1ns/1ps
`default_nettype none
module mdio_host_model (
  output logic      mdc,
  output logic      mdioIn,
  input  wire logic mdioOut,
  input  wire logic mdioOe
);
  logic hostBit = 1'b1;
  logic hostOe  = 1'b1;
  // Wired level, pull-up when nobody drives
  assign mdioIn = mdioOe ? mdioOut : (hostOe ? hostBit : 1'b1);
  initial mdc = 1'b0;
  // One bit: change while low, sample at rising edge, 48 ns period
  task automatic bit_cycle(input logic b, input logic drive, output logic s);
    hostBit = b;
    hostOe = drive;
    #24 mdc = 1'b1;
    s = mdioIn;
    #24 mdc = 1'b0;
  endtask
  task automatic idle(input int n);
    logic s;
    for (int i = 0; i < n; i++) bit_cycle(1'b1, 1'b1, s);
  endtask
  // Full frame with preamble; host lets go of turnaround and data on reads
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] bits;
    logic        s;
    bits = {32'hffffffff, 2'b01, op, phy, ra, 2'b10, wd};
    for (int i = 63; i >= 0; i--) begin
      bit_cycle(bits[i], (op == 2'b01) || (i > 17), s);
      if (i < 16) rd[i] = s;
    end
    hostOe = 1'b1;
    hostBit = 1'b1;
  endtask
endmodule // mdio_host_model
`default_nettype wire

// file: serdes_one_to_one_provisioning.sv
// Management register bank of a dual-channel serdes in one-to-one mode.
// Assumes the host drives MDC/MDIO; health inputs are asynchronous levels.
//
// Summary of operation
// - Writing one to register 0 bit 15 soft-resets the whole device.
// - With register 0 bit 11 set, each write reaches both channels.
// - Register 1 bit 13 selects one-to-one receive deserialization.
// - Register 1 bit 12 selects the transmit serialization mode.
// - Register 1 bit 1 picks reference input 0 or 1, default 0.
// - Fast side multiplier and rate fields live in registers 2 and 3.
// - Slow side multiplier and rate fields live in registers 6 and 7.
// - Registers 2 to 8 hold tunable fields, set before receiver enable.
// - Health register bits 1 and 0 report slow and fast PLL lock.
// - Writing one to register 0x0E bit 3 flushes the data path.
// - Reading the health register clears its latched bits.
// - Healthy: loss bit 13 zero, autozero bit 12 and gain bit 11 one.
// - Bits 7 to 4 report transmit and receive FIFO under and overflow.
`timescale 1ns/1ps
`default_nettype none
module serdes_one_to_one_provisioning
  import serdes_prov_pkg::*;
#(
  parameter logic [4:0] PHY_BASE = 5'h00
) (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       clockEnable,
  input  wire logic       mdc,
  input  wire logic       mdioIn,
  output var  logic       mdioOut,
  output var  logic       mdioOe,
  input  wire logic       chanAPowerdownN,
  input  wire logic       chanBPowerdownN,
  input  wire logic [1:0] fastSideLocked,
  input  wire logic [1:0] slowSideLocked,
  input  wire logic [1:0] fastSideSignalLost,
  input  wire logic [1:0] fastSideAutozeroComplete,
  input  wire logic [1:0] fastSideGainSettled,
  input  wire logic [7:0] fifoFault,
  output var  logic [1:0] refInputChoice,
  output var  logic [1:0] rxOneToOne,
  output var  logic [1:0] txSerialMode,
  output var  logic [1:0] fastSideReceiverOn,
  output var  logic [1:0] dataPathFlush,
  output var  logic       deviceSoftReset
);

  logic        reqChan;
  logic [4:0]  reqReg;
  logic [15:0] reqData;
  logic        rdToggle;
  logic        wrToggle;
  logic [2:0]  rdSync_q;
  logic [2:0]  wrSync_q;
  logic        rdEvent;
  logic        wrEvent;

  logic [19:0] rawStatus;
  logic [19:0] statusMeta_q;
  logic [19:0] statusSync_q;
  logic [1:0][8:0] liveBad;
  logic [1:0]  poweredUp;

  logic [1:0][8:0] sticky_q, sticky_d;
  logic        globalWrite_q, globalWrite_d;
  logic [1:0][2:0] chanCtrl_q, chanCtrl_d;
  logic [1:0]  rxOn_q, rxOn_d;
  logic [1:0]  flush_q, flush_d;
  logic        softRst_q, softRst_d;
  logic [15:0] rdWord_q, rdWord_d;
  logic        ack_q, ack_d;

  logic [1:0]  wrMask;
  logic        cfgHit;
  logic [4:0]  cfgOffset;
  logic [15:0] memRead;
  logic [15:0] readValue;

  mdio_frame_engine #(
    .PHY_BASE (PHY_BASE)
  ) u_engine (
    .mdc       (mdc),
    .reset     (reset),
    .mdioIn    (mdioIn),
    .mdioOut   (mdioOut),
    .mdioOe    (mdioOe),
    .rdWord    (rdWord_q),
    .ackToggle (ack_q),
    .reqChan   (reqChan),
    .reqReg    (reqReg),
    .reqData   (reqData),
    .rdToggle  (rdToggle),
    .wrToggle  (wrToggle)
  );

  // Request decode
  assign rdEvent = rdSync_q[2] ^ rdSync_q[1];
  assign wrEvent = wrSync_q[2] ^ wrSync_q[1];
  assign wrMask = globalWrite_q ? 2'b11 : (reqChan ? 2'b10 : 2'b01);
  assign cfgHit = (reqReg >= REG_CFG_FIRST) && (reqReg <= REG_CFG_LAST);
  assign cfgOffset = reqReg - REG_CFG_FIRST;

  config_store #(
    .W     (DATA_W),
    .IDX_W (CFG_IDX_W)
  ) u_store (
    .clock       (clock),
    .reset       (reset),
    .clockEnable (clockEnable),
    .softClear   (softRst_q),
    .writeEnable (wrEvent & cfgHit),
    .writeMask   (wrMask),
    .writeIndex  (cfgOffset[CFG_IDX_W-1:0]),
    .writeData   (reqData),
    .readChan    (reqChan),
    .readIndex   (cfgOffset[CFG_IDX_W-1:0]),
    .readData    (memRead)
  );

  // Health inputs, nine bits per channel plus powerdown pins
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      rawStatus[9*c +: 9] = {fastSideSignalLost[c], fastSideAutozeroComplete[c],
                             fastSideGainSettled[c], fifoFault[4*c +: 4],
                             slowSideLocked[c], fastSideLocked[c]};
    end
    rawStatus[18] = chanAPowerdownN;
    rawStatus[19] = chanBPowerdownN;
  end

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      liveBad[c] = statusSync_q[9*c +: 9] ^ BAD_INVERT;
    end
    poweredUp = statusSync_q[19:18];
  end

  // Register read value
  always_comb begin
    readValue = 16'h0000;
    case (reqReg)
      REG_GLOBAL: begin
        readValue[BIT_GLOBAL_WRITE] = globalWrite_q;
      end
      REG_CHAN_CTRL: begin
        readValue[BIT_RX_ONE] = chanCtrl_q[reqChan][2];
        readValue[BIT_TX_MODE] = chanCtrl_q[reqChan][1];
        readValue[BIT_REF_SEL] = chanCtrl_q[reqChan][0];
      end
      REG_HEALTH: begin
        readValue = health_word(sticky_q[reqChan] | liveBad[reqChan]);
      end
      default: begin
        readValue = cfgHit ? memRead : 16'h0000;
      end
    endcase
  end

  // Next state of the register bank
  always_comb begin
    globalWrite_d = globalWrite_q;
    chanCtrl_d = chanCtrl_q;
    rxOn_d = rxOn_q;
    flush_d = 2'b00;
    softRst_d = 1'b0;
    rdWord_d = rdWord_q;
    ack_d = ack_q;
    for (int c = 0; c < 2; c++) begin
      if (rdEvent && reqReg == REG_HEALTH && reqChan == c[0]) begin
        sticky_d[c] = liveBad[c];
      end else begin
        sticky_d[c] = sticky_q[c] | liveBad[c];
      end
    end
    if (rdEvent) begin
      rdWord_d = readValue;
      ack_d = ~ack_q;
    end
    if (wrEvent) begin
      case (reqReg)
        REG_GLOBAL: begin
          globalWrite_d = reqData[BIT_GLOBAL_WRITE];
          softRst_d = reqData[BIT_SOFT_RESET];
        end
        REG_CHAN_CTRL: begin
          for (int c = 0; c < 2; c++) begin
            if (wrMask[c]) begin
              chanCtrl_d[c][2] = reqData[BIT_RX_ONE];
              chanCtrl_d[c][1] = reqData[BIT_TX_MODE];
              chanCtrl_d[c][0] = reqData[BIT_REF_SEL];
            end
          end
        end
        REG_HS_CONFIG_B: begin
          for (int c = 0; c < 2; c++) begin
            if (wrMask[c]) begin
              rxOn_d[c] = reqData[BIT_RX_ON];
            end
          end
        end
        REG_DP_CTRL: begin
          flush_d = wrMask & {2{reqData[BIT_FLUSH]}};
        end
        default: begin
        end
      endcase
    end
    if (softRst_q) begin
      globalWrite_d = 1'b0;
      chanCtrl_d = '0;
      rxOn_d = {2{RST_HS_CONFIG_B[BIT_RX_ON]}};
      flush_d = 2'b00;
      for (int c = 0; c < 2; c++) begin
        sticky_d[c] = liveBad[c];
      end
    end
  end

  // Crossings and health synchronisers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdSync_q <= 3'b000;
      wrSync_q <= 3'b000;
      statusMeta_q <= {2'b11, BAD_INVERT, BAD_INVERT};
      statusSync_q <= {2'b11, BAD_INVERT, BAD_INVERT};
    end else if (clockEnable) begin
      rdSync_q <= {rdSync_q[1:0], rdToggle};
      wrSync_q <= {wrSync_q[1:0], wrToggle};
      statusMeta_q <= rawStatus;
      statusSync_q <= statusMeta_q;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sticky_q <= '0;
      globalWrite_q <= 1'b0;
      chanCtrl_q <= '0;
      rxOn_q <= {2{RST_HS_CONFIG_B[BIT_RX_ON]}};
      flush_q <= 2'b00;
      softRst_q <= 1'b0;
      rdWord_q <= 16'h0000;
      ack_q <= 1'b0;
    end else if (clockEnable) begin
      sticky_q <= sticky_d;
      globalWrite_q <= globalWrite_d;
      chanCtrl_q <= chanCtrl_d;
      rxOn_q <= rxOn_d;
      flush_q <= flush_d;
      softRst_q <= softRst_d;
      rdWord_q <= rdWord_d;
      ack_q <= ack_d;
    end
  end

  // Channel controls; a powered-down channel keeps its receiver off
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      rxOneToOne[c] = chanCtrl_q[c][2];
      txSerialMode[c] = chanCtrl_q[c][1];
      refInputChoice[c] = chanCtrl_q[c][0];
      fastSideReceiverOn[c] = rxOn_q[c] & poweredUp[c];
    end
    dataPathFlush = flush_q;
    deviceSoftReset = softRst_q;
  end

endmodule // serdes_one_to_one_provisioning
`default_nettype wire

// file: serdes_prov_asserts.sv
// Port-level checks on the serdes provisioning bank, bound to its top.
// Assumes mdc idles between frames; reset is asynchronous, active high.
`timescale 1ns/1ps
`default_nettype none
module serdes_prov_asserts (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       clockEnable,
  input wire logic       mdc,
  input wire logic       mdioIn,
  input wire logic       mdioOut,
  input wire logic       mdioOe,
  input wire logic       chanAPowerdownN,
  input wire logic       chanBPowerdownN,
  input wire logic [1:0] fastSideLocked,
  input wire logic [1:0] slowSideLocked,
  input wire logic [1:0] fastSideSignalLost,
  input wire logic [1:0] fastSideAutozeroComplete,
  input wire logic [1:0] fastSideGainSettled,
  input wire logic [7:0] fifoFault,
  input wire logic [1:0] refInputChoice,
  input wire logic [1:0] rxOneToOne,
  input wire logic [1:0] txSerialMode,
  input wire logic [1:0] fastSideReceiverOn,
  input wire logic [1:0] dataPathFlush,
  input wire logic       deviceSoftReset
);
  a_flush_pulse: assert property (@(posedge clock) disable iff (reset)
    (dataPathFlush != 2'b00 && clockEnable) |=> dataPathFlush == 2'b00)
    else $error("flush pulse longer than one cycle");
  a_soft_pulse: assert property (@(posedge clock) disable iff (reset)
    (deviceSoftReset && clockEnable) |=> !deviceSoftReset)
    else $error("soft reset pulse longer than one cycle");
  a_soft_clears_modes: assert property (@(posedge clock) disable iff (reset)
    (deviceSoftReset && clockEnable) |-> ##[1:3]
    (rxOneToOne == 2'b00 && txSerialMode == 2'b00 && refInputChoice == 2'b00))
    else $error("mode outputs not cleared by soft reset");
  a_rx_gate_a: assert property (@(posedge clock) disable iff (reset)
    (!chanAPowerdownN && clockEnable) [*4] |-> !fastSideReceiverOn[0])
    else $error("receiver A on while powered down");
  a_rx_gate_b: assert property (@(posedge clock) disable iff (reset)
    (!chanBPowerdownN && clockEnable) [*4] |-> !fastSideReceiverOn[1])
    else $error("receiver B on while powered down");
  a_modes_frozen: assert property (@(posedge clock) disable iff (reset)
    !clockEnable |=> $stable(rxOneToOne) && $stable(txSerialMode) && $stable(refInputChoice))
    else $error("mode outputs moved while clock enable low");
  a_read_span: assert property (@(posedge mdc) disable iff (reset)
    $rose(mdioOe) |-> mdioOe [*8] ##1 mdioOe [*8] ##1 mdioOe ##1 !mdioOe)
    else $error("read drive window not seventeen bits");
  a_turn_zero: assert property (@(posedge mdc) disable iff (reset)
    $rose(mdioOe) |-> !mdioOut)
    else $error("turnaround bit not zero");
endmodule // serdes_prov_asserts
bind serdes_one_to_one_provisioning serdes_prov_asserts serdes_prov_asserts_inst (
  .clock, .reset, .clockEnable, .mdc, .mdioIn, .mdioOut, .mdioOe, .chanAPowerdownN,
  .chanBPowerdownN, .fastSideLocked, .slowSideLocked, .fastSideSignalLost,
  .fastSideAutozeroComplete, .fastSideGainSettled, .fifoFault, .refInputChoice,
  .rxOneToOne, .txSerialMode, .fastSideReceiverOn, .dataPathFlush, .deviceSoftReset);
`default_nettype wire

// file: serdes_prov_pkg.sv
// Constants, types and helpers for the serdes provisioning register bank.
// Assumes a Clause 22 management frame format on the link.
package serdes_prov_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned CFG_IDX_W = 3;

  // Register offsets
  localparam logic [4:0] REG_GLOBAL      = 5'h00;
  localparam logic [4:0] REG_CHAN_CTRL   = 5'h01;
  localparam logic [4:0] REG_CFG_FIRST   = 5'h02;
  localparam logic [4:0] REG_HS_CONFIG_A = 5'h02;
  localparam logic [4:0] REG_HS_CONFIG_B = 5'h03;
  localparam logic [4:0] REG_LS_CONFIG_A = 5'h06;
  localparam logic [4:0] REG_LS_CONFIG_B = 5'h07;
  localparam logic [4:0] REG_CFG_LAST    = 5'h08;
  localparam logic [4:0] REG_DP_CTRL     = 5'h0e;
  localparam logic [4:0] REG_HEALTH      = 5'h0f;

  // Field positions
  localparam int unsigned BIT_SOFT_RESET   = 15;
  localparam int unsigned BIT_GLOBAL_WRITE = 11;
  localparam int unsigned BIT_RX_ONE       = 13;
  localparam int unsigned BIT_TX_MODE      = 12;
  localparam int unsigned BIT_REF_SEL      = 1;
  localparam int unsigned BIT_RX_ON        = 2;
  localparam int unsigned BIT_FLUSH        = 3;
  localparam int unsigned BIT_LOS          = 13;
  localparam int unsigned BIT_AZ_DONE      = 12;
  localparam int unsigned BIT_AGC_LOCK     = 11;
  localparam int unsigned BIT_FIFO_LO      = 4;
  localparam int unsigned BIT_SLOW_LOCK    = 1;
  localparam int unsigned BIT_FAST_LOCK    = 0;

  // Values after reset
  localparam logic [15:0] RST_HS_CONFIG_A = 16'h8110;
  localparam logic [15:0] RST_HS_CONFIG_B = 16'ha440;
  localparam logic [15:0] RST_LS_CONFIG_A = 16'hf110;
  localparam logic [15:0] RST_LS_CONFIG_B = 16'hdc04;
  localparam logic [15:0] RST_CFG_OTHER   = 16'h0000;

  // Health inputs whose healthy level is high
  localparam logic [8:0] BAD_INVERT = 9'h0c3;

  // Frame layout
  localparam logic [5:0] PREAMBLE_LEN = 6'd32;
  localparam logic [1:0] OP_READ      = 2'b10;
  localparam logic [1:0] OP_WRITE     = 2'b01;
  localparam logic [3:0] HDR_LAST     = 4'hb;
  localparam logic [3:0] TA_LAST      = 4'h1;
  localparam logic [3:0] DATA_LAST    = 4'hf;

  typedef enum logic [2:0] {
    FR_PREAMBLE = 3'b000,
    FR_START    = 3'b001,
    FR_HEADER   = 3'b010,
    FR_TURN     = 3'b011,
    FR_DATA     = 3'b100
  } frame_state_t;

  function automatic logic [15:0] cfg_reset_value(input logic [2:0] idx);
    logic [4:0] r;
    r = REG_CFG_FIRST + {2'b00, idx};
    case (r)
      REG_HS_CONFIG_A: cfg_reset_value = RST_HS_CONFIG_A;
      REG_HS_CONFIG_B: cfg_reset_value = RST_HS_CONFIG_B;
      REG_LS_CONFIG_A: cfg_reset_value = RST_LS_CONFIG_A;
      REG_LS_CONFIG_B: cfg_reset_value = RST_LS_CONFIG_B;
      default:         cfg_reset_value = RST_CFG_OTHER;
    endcase
  endfunction

  // bad = {los, !az, !agc, txU, txO, rxU, rxO, !slowLock, !fastLock}
  function automatic logic [15:0] health_word(input logic [8:0] bad);
    health_word = 16'h0000;
    health_word[BIT_LOS] = bad[8];
    health_word[BIT_AZ_DONE] = ~bad[7];
    health_word[BIT_AGC_LOCK] = ~bad[6];
    health_word[BIT_FIFO_LO +: 4] = bad[5:2];
    health_word[BIT_SLOW_LOCK] = ~bad[1];
    health_word[BIT_FAST_LOCK] = ~bad[0];
  endfunction

endpackage

// file: testbench.sv
// Self-checking bench for the serdes provisioning bank over management frames.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import serdes_prov_pkg::*;
;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        clockEnable = 1'b1;
  logic        chanAPowerdownN = 1'b1;
  logic        chanBPowerdownN = 1'b1;
  logic [1:0]  fastSideLocked = 2'b11;
  logic [1:0]  slowSideLocked = 2'b11;
  logic [1:0]  fastSideSignalLost = 2'b00;
  logic [1:0]  fastSideAutozeroComplete = 2'b11;
  logic [1:0]  fastSideGainSettled = 2'b11;
  logic [7:0]  fifoFault = 8'h00;
  logic        mdc, mdioIn, mdioOut, mdioOe, deviceSoftReset;
  logic [1:0]  refInputChoice, rxOneToOne, txSerialMode, fastSideReceiverOn, dataPathFlush;
  logic [15:0] x;
  int          fail_count = 0, tests_run = 0, flushA = 0, flushB = 0, softCnt = 0, f0, f1, s0;
  wire logic [15:0] outs = {8'h00, rxOneToOne, txSerialMode, refInputChoice, fastSideReceiverOn};

  always #5 clock = ~clock;
  always @(posedge clock) begin
    flushA <= flushA + int'(dataPathFlush[0]);
    flushB <= flushB + int'(dataPathFlush[1]);
    softCnt <= softCnt + int'(deviceSoftReset);
  end

  serdes_one_to_one_provisioning serdes_one_to_one_provisioning_inst (
    .clock, .reset, .clockEnable, .mdc, .mdioIn, .mdioOut, .mdioOe, .chanAPowerdownN,
    .chanBPowerdownN, .fastSideLocked, .slowSideLocked, .fastSideSignalLost,
    .fastSideAutozeroComplete, .fastSideGainSettled, .fifoFault, .refInputChoice,
    .rxOneToOne, .txSerialMode, .fastSideReceiverOn, .dataPathFlush, .deviceSoftReset);
  mdio_host_model mdio_host_model_inst (.mdc, .mdioIn, .mdioOut, .mdioOe);

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic c, input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] y;
    mdio_host_model_inst.frame(OP_WRITE, {4'h0, c}, ra, d, y);
    cyc(8);
  endtask
  task automatic rd(input logic c, input logic [4:0] ra, output logic [15:0] d);
    mdio_host_model_inst.frame(OP_READ, {4'h0, c}, ra, 16'h0000, d);
    cyc(8);
  endtask
  task automatic rc(input logic c, input logic [4:0] ra, input logic [15:0] e);
    logic [15:0] y;
    rd(c, ra, y);
    chk(y, e);
  endtask
  // Pulse a fault, remove it, then read latched, other channel, cleared
  task automatic pulse_check(input logic c, input logic [7:0] ff, input logic [1:0] los,
                             input logic [1:0] lk, input logic [15:0] exp);
    @(posedge clock);
    fifoFault <= ff;
    fastSideSignalLost <= los;
    {fastSideLocked, slowSideLocked} <= {lk, lk};
    {fastSideAutozeroComplete, fastSideGainSettled} <= {lk, lk};
    cyc(5);
    fifoFault <= 8'h00;
    fastSideSignalLost <= 2'b00;
    {fastSideLocked, slowSideLocked} <= 4'hf;
    {fastSideAutozeroComplete, fastSideGainSettled} <= 4'hf;
    cyc(5);
    rc(c, REG_HEALTH, exp);
    rc(!c, REG_HEALTH, 16'h1803);
    rc(c, REG_HEALTH, 16'h1803);
  endtask

  initial begin
    #400000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    fork
      mdio_host_model_inst.idle(3);
      repeat (20) @(posedge clock);
    join
    reset <= 1'b0;
    cyc(2);
    chk(outs, 16'h0000);
    rc(1'b0, REG_HEALTH, 16'h1803);
    rc(1'b0, REG_HS_CONFIG_A, 16'h8110);
    rc(1'b1, REG_LS_CONFIG_B, 16'hdc04);
    rc(1'b0, 5'h0a, 16'h0000);
    rc(1'b1, REG_DP_CTRL, 16'h0000);
    $display("test reset values done");
    wr(1'b0, REG_GLOBAL, 16'h0800);
    wr(1'b0, REG_CHAN_CTRL, 16'h2002);
    wr(1'b0, REG_HS_CONFIG_A, 16'h811d);
    wr(1'b0, REG_HS_CONFIG_B, 16'ha541);
    wr(1'b0, REG_LS_CONFIG_A, 16'hf119);
    wr(1'b0, 5'h08, 16'h0f70);
    chk(outs, 16'h00cc);
    rc(1'b1, REG_HS_CONFIG_A, 16'h811d);
    rc(1'b1, REG_LS_CONFIG_A, 16'hf119);
    rc(1'b1, REG_LS_CONFIG_B, 16'hdc04);
    rc(1'b1, 5'h08, 16'h0f70);
    wr(1'b0, REG_HS_CONFIG_B, 16'ha545);
    rc(1'b1, REG_HS_CONFIG_B, 16'ha545);
    chk(outs, 16'h00cf);
    chanAPowerdownN <= 1'b0;
    cyc(6);
    chk(outs, 16'h00ce);
    chanAPowerdownN <= 1'b1;
    chanBPowerdownN <= 1'b0;
    cyc(6);
    chk(outs, 16'h00cd);
    chanBPowerdownN <= 1'b1;
    $display("test global write and modes done");
    f0 = flushA;
    f1 = flushB;
    wr(1'b0, REG_DP_CTRL, 16'h0008);
    chk(16'((flushB - f1) * 16 + flushA - f0), 16'h0011);
    wr(1'b0, REG_GLOBAL, 16'h0000);
    wr(1'b1, REG_DP_CTRL, 16'h0008);
    chk(16'((flushB - f1) * 16 + flushA - f0), 16'h0021);
    wr(1'b1, REG_CHAN_CTRL, 16'h1000);
    chk(outs, 16'h0067);
    rc(1'b0, REG_CHAN_CTRL, 16'h2002);
    @(posedge clock);
    clockEnable <= 1'b0;
    cyc(10);
    clockEnable <= 1'b1;
    $display("test flush and per channel done");
    rd(1'b0, REG_HEALTH, x);
    rd(1'b1, REG_HEALTH, x);
    rc(1'b0, REG_HEALTH, 16'h1803);
    rc(1'b1, REG_HEALTH, 16'h1803);
    pulse_check(1'b1, 8'h40, 2'b00, 2'b11, 16'h1843);
    pulse_check(1'b0, 8'h09, 2'b00, 2'b11, 16'h1893);
    pulse_check(1'b0, 8'h00, 2'b01, 2'b11, 16'h3803);
    pulse_check(1'b1, 8'h00, 2'b00, 2'b01, 16'h0000);
    $display("test health flags done");
    s0 = softCnt;
    wr(1'b0, REG_GLOBAL, 16'h8000);
    chk(16'(softCnt - s0), 16'h0001);
    chk(outs, 16'h0000);
    rc(1'b1, REG_HS_CONFIG_B, 16'ha440);
    rc(1'b0, REG_GLOBAL, 16'h0000);
    $display("test soft reset done");
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
